/* File: hdl/upstream_err_cfg.svh */
// Offsets, bit positions and reset values of the upstream error block.
// Assumes Avalon-MM byte addresses with one aligned 32-bit word per register.
`ifndef UPSTREAM_ERR_CFG_SVH
`define UPSTREAM_ERR_CFG_SVH
`define OFS_SEC_STATUS   8'h00
`define OFS_SEC_MASK     8'h04
`define OFS_SEC_SEVERITY 8'h08
`define OFS_SEC_ERR_CTRL 8'h0C
`define OFS_SEC_HDR_LOG  8'h10
`define OFS_PRI_STATUS   8'h14
`define OFS_PRI_MASK     8'h18
`define OFS_PRI_SEVERITY 8'h1C
`define OFS_PCI_CSR      8'h20
`define OFS_SEC_PCI_STAT 8'h24
`define OFS_BRIDGE_CTRL  8'h28
`define OFS_DEV_CSR      8'h2C
`define BIT_PTR_VALID    7
`define BIT_SYS_ERR_EN   0
`define BIT_SIG_SYS_ERR  1
`define BIT_RCV_MABORT   2
`define BIT_RCV_TABORT   3
`define BIT_DET_PERR     0
`define BIT_SIG_TABORT   1
`define BIT_SEC_RTABORT  2
`define BIT_PERR_RESP_EN 0
`define BIT_MABORT_MODE  1
`define BIT_DISCARD_EN   2
`define BIT_FATAL_EN     0
`define BIT_NONFATAL_EN  1
`define BIT_FATAL_DET    2
`define BIT_NONFATAL_DET 3
`define RST_MASK         4'h0
`define RST_SEVERITY     4'h0
`define RST_BRIDGE_CTRL  3'h0
`endif

/* File: hdl/upstream_err_pkg.sv */
// Types shared by the upstream error block.
// Assumes the cfg header supplies all offsets and bit positions.
package upstream_err_pkg;
    // Secondary causes, in status bit order; also the first-error pointer code.
    typedef enum logic [1:0] {
        CAUSE_PERR_SEEN,
        CAUSE_ADDR_PARITY,
        CAUSE_ATTR_PARITY,
        CAUSE_DISCARD_TIMEOUT
    } cause_type;
    typedef logic [3:0] cause_vec_type;
endpackage

/* File: hdl/upstream_bridge_error_handler.sv */
// Upstream error handling for a bridge whose secondary side runs PCI.
// Assumes event inputs are one-cycle pulses from logic on MCLK.
`include "upstream_err_cfg.svh"

// Overview of operation
// - Master PERR does not stop completion forwarding.
// - Master PERR sets parity-assert-seen status.
// - Unmasked parity cause logs header if pointer invalid.
// - Unmasked cause sends message of its severity when reporting is enabled.
// - Poisoned completion: same logging, no message.
// - Message with system enable sets signalled system error.
// - Reported error sets fatal or nonfatal detected.
// - Address parity handled when parity response enabled.
// - Parity handling: target abort, discard, signalled abort.
// - Address or attribute parity sets detected parity.
// - Address and attribute parity have own bits.
// - Abort mode set: unsupported request gives abort.
// - Abort mode clear: unsupported read returns ones.
// - Abort mode clear: unsupported write completes, discarded.
// - Unsupported request always sets received master abort.
// - Completer abort sets secondary received target abort.
// - Completer abort: data so far, then abort.
// - Completion timeout handled like unsupported request.
// - Completion timeout sets status, reports by severity.
// - Discard timeout reports if unmasked or enabled.
module upstream_bridge_error_handler
    import upstream_err_pkg::*;
#(
    parameter int HDR_W = 32
)
(
    input  wire logic             MCLK,
    input  wire logic             SRST,
    input  wire logic [7:0]       AVS_ADDRESS,
    input  wire logic             AVS_READ,
    input  wire logic             AVS_WRITE,
    input  wire logic [31:0]      AVS_WRITEDATA,
    input  wire logic [3:0]       AVS_BYTEENABLE,
    output logic      [31:0]      AVS_READDATA,
    output logic                  AVS_WAITREQUEST,
    input  wire logic             RD_PERR,
    input  wire logic             RD_POISONED,
    input  wire logic [HDR_W-1:0] RD_HDR,
    input  wire logic             ADDR_PERR,
    input  wire logic             ATTR_PERR,
    input  wire logic [HDR_W-1:0] PCI_HDR,
    input  wire logic             CPL_UR,
    input  wire logic             CPL_CA,
    input  wire logic             CPL_TO,
    input  wire logic             REQ_IS_READ,
    input  wire logic             DT_TIMEOUT,
    output logic                  MSG_VALID,
    output logic                  MSG_FATAL,
    output logic                  TERM_VALID,
    output logic                  TERM_TARGET_ABORT,
    output logic                  TERM_ALL_ONES,
    output logic                  TERM_DISCARD,
    output logic                  STREAM_STOP
);
    cause_vec_type    sec_status;
    cause_vec_type    sec_mask;
    cause_vec_type    sec_sev;
    logic             ptr_valid;
    cause_type        first_error_pointer;
    logic [HDR_W-1:0] hdr_log;
    logic             completion_timeout_status;
    logic             pri_mask;
    logic             pri_sev;
    logic             system_error_enable;
    logic             signalled_system_error;
    logic             received_master_abort;
    logic             received_target_abort;
    logic             detected_parity_error;
    logic             signalled_target_abort;
    logic             sec_received_abort;
    logic             secondary_parity_response_enable;
    logic             master_abort_mode;
    logic             discard_timeout_syserr_enable;
    logic             fatal_report_enable;
    logic             nonfatal_report_enable;
    logic             fatal_detected;
    logic             nonfatal_detected;
    logic             served;
    logic             wr_now;
    logic [31:0]      wdat;
    logic [31:0]      next_rdata;
    cause_vec_type    sec_event;
    cause_vec_type    sec_hit;
    cause_vec_type    sec_report;
    logic [2:0]       log_event;
    logic             to_hit;
    logic             to_report;
    logic             any_report;
    logic             ur_like;
    logic             parity_abort;

    // Reporting is allowed by the system enable or the enable of matching severity.
    function automatic logic may_report(input logic fatal);
        may_report = system_error_enable |
                     (fatal ? fatal_report_enable : nonfatal_report_enable);
    endfunction

    function automatic logic reg_hit(input logic [7:0] offset);
        reg_hit = wr_now && (AVS_ADDRESS == offset);
    endfunction

    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    // A request waits exactly one cycle, then is served.
    assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~served;
    assign wr_now          = AVS_WRITE & served;
    assign wdat            = AVS_WRITEDATA & lane_mask(AVS_BYTEENABLE);

    always_ff @(posedge MCLK)
    begin
        if (SRST)
            served <= 1'b0;
        else
            served <= (AVS_READ | AVS_WRITE) & ~served;
    end

    always_comb
    begin
        next_rdata = 32'h0000_0000;
        case (AVS_ADDRESS)
            `OFS_SEC_STATUS:   next_rdata[3:0] = sec_status;
            `OFS_SEC_MASK:     next_rdata[3:0] = sec_mask;
            `OFS_SEC_SEVERITY: next_rdata[3:0] = sec_sev;
            `OFS_SEC_ERR_CTRL:
            begin
                next_rdata[1:0]            = first_error_pointer;
                next_rdata[`BIT_PTR_VALID] = ptr_valid;
            end
            `OFS_SEC_HDR_LOG:  next_rdata[HDR_W-1:0] = hdr_log;
            `OFS_PRI_STATUS:   next_rdata[0] = completion_timeout_status;
            `OFS_PRI_MASK:     next_rdata[0] = pri_mask;
            `OFS_PRI_SEVERITY: next_rdata[0] = pri_sev;
            `OFS_PCI_CSR:
            begin
                next_rdata[`BIT_SYS_ERR_EN]  = system_error_enable;
                next_rdata[`BIT_SIG_SYS_ERR] = signalled_system_error;
                next_rdata[`BIT_RCV_MABORT]  = received_master_abort;
                next_rdata[`BIT_RCV_TABORT]  = received_target_abort;
            end
            `OFS_SEC_PCI_STAT:
            begin
                next_rdata[`BIT_DET_PERR]    = detected_parity_error;
                next_rdata[`BIT_SIG_TABORT]  = signalled_target_abort;
                next_rdata[`BIT_SEC_RTABORT] = sec_received_abort;
            end
            `OFS_BRIDGE_CTRL:
            begin
                next_rdata[`BIT_PERR_RESP_EN] = secondary_parity_response_enable;
                next_rdata[`BIT_MABORT_MODE]  = master_abort_mode;
                next_rdata[`BIT_DISCARD_EN]   = discard_timeout_syserr_enable;
            end
            `OFS_DEV_CSR:
            begin
                next_rdata[`BIT_FATAL_EN]     = fatal_report_enable;
                next_rdata[`BIT_NONFATAL_EN]  = nonfatal_report_enable;
                next_rdata[`BIT_FATAL_DET]    = fatal_detected;
                next_rdata[`BIT_NONFATAL_DET] = nonfatal_detected;
            end
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge MCLK)
    begin
        if (SRST)
            AVS_READDATA <= 32'h0000_0000;
        else if (AVS_READ && !served)
            AVS_READDATA <= next_rdata;
    end

    // Software-owned controls.
    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            sec_mask <= `RST_MASK;
            sec_sev  <= `RST_SEVERITY;
            pri_mask <= 1'b0;
            pri_sev  <= 1'b0;
            system_error_enable              <= 1'b0;
            fatal_report_enable              <= 1'b0;
            nonfatal_report_enable           <= 1'b0;
            {discard_timeout_syserr_enable, master_abort_mode,
             secondary_parity_response_enable} <= `RST_BRIDGE_CTRL;
        end
        else
        begin
            if (reg_hit(`OFS_SEC_MASK))
                sec_mask <= wdat[3:0];
            if (reg_hit(`OFS_SEC_SEVERITY))
                sec_sev <= wdat[3:0];
            if (reg_hit(`OFS_PRI_MASK))
                pri_mask <= wdat[0];
            if (reg_hit(`OFS_PRI_SEVERITY))
                pri_sev <= wdat[0];
            if (reg_hit(`OFS_PCI_CSR))
                system_error_enable <= wdat[`BIT_SYS_ERR_EN];
            if (reg_hit(`OFS_DEV_CSR))
            begin
                fatal_report_enable    <= wdat[`BIT_FATAL_EN];
                nonfatal_report_enable <= wdat[`BIT_NONFATAL_EN];
            end
            if (reg_hit(`OFS_BRIDGE_CTRL))
            begin
                secondary_parity_response_enable <= wdat[`BIT_PERR_RESP_EN];
                master_abort_mode                <= wdat[`BIT_MABORT_MODE];
                discard_timeout_syserr_enable    <= wdat[`BIT_DISCARD_EN];
            end
        end
    end

    // Cause decode. Address or attribute parity is aborted only with parity response on.
    assign sec_event = {DT_TIMEOUT, ATTR_PERR, ADDR_PERR, RD_PERR};
    assign sec_hit[2:0] = sec_event[2:0] & ~sec_mask[2:0];
    assign sec_hit[3] = DT_TIMEOUT &
                        (~sec_mask[3] | discard_timeout_syserr_enable);
    assign log_event  = sec_hit[2:0];
    assign sec_report[0] = sec_hit[0] & ~RD_POISONED & may_report(sec_sev[0]);
    assign sec_report[1] = sec_hit[1] & may_report(sec_sev[1]);
    assign sec_report[2] = sec_hit[2] & may_report(sec_sev[2]);
    assign sec_report[3] = sec_hit[3] & may_report(sec_sev[3]);
    assign to_hit     = CPL_TO & ~pri_mask;
    assign to_report  = to_hit & may_report(pri_sev);
    assign any_report = (|sec_report) | to_report;
    assign ur_like    = CPL_UR | CPL_TO;
    assign parity_abort = (ADDR_PERR | ATTR_PERR) &
                          secondary_parity_response_enable;

    // Status bits are sticky; a set in the same cycle as a clear wins.
    always_ff @(posedge MCLK)
    begin
        if (SRST)
            sec_status <= 4'h0;
        else
            sec_status <= (sec_status &
                           ~(reg_hit(`OFS_SEC_STATUS) ? wdat[3:0] : 4'h0))
                          | sec_event;
    end

    always_ff @(posedge MCLK)
    begin
        if (SRST)
            completion_timeout_status <= 1'b0;
        else
            completion_timeout_status <= (completion_timeout_status &
                ~(reg_hit(`OFS_PRI_STATUS) & wdat[0])) | CPL_TO;
    end

    // Only the first unmasked parity cause is logged until software frees the pointer.
    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            ptr_valid           <= 1'b0;
            first_error_pointer <= CAUSE_PERR_SEEN;
            hdr_log             <= '0;
        end
        else if (!ptr_valid && (|log_event))
        begin
            ptr_valid <= 1'b1;
            if (log_event[0])
            begin
                first_error_pointer <= CAUSE_PERR_SEEN;
                hdr_log             <= RD_HDR;
            end
            else if (log_event[1])
            begin
                first_error_pointer <= CAUSE_ADDR_PARITY;
                hdr_log             <= PCI_HDR;
            end
            else
            begin
                first_error_pointer <= CAUSE_ATTR_PARITY;
                hdr_log             <= PCI_HDR;
            end
        end
        else if (reg_hit(`OFS_SEC_ERR_CTRL) && wdat[`BIT_PTR_VALID])
            ptr_valid <= 1'b0;
    end

    // One message per cycle of events; fatal wins when severities mix.
    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            MSG_VALID <= 1'b0;
            MSG_FATAL <= 1'b0;
        end
        else
        begin
            MSG_VALID <= any_report;
            MSG_FATAL <= (|(sec_report & sec_sev)) | (to_report & pri_sev);
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            signalled_system_error <= 1'b0;
            received_master_abort  <= 1'b0;
            received_target_abort  <= 1'b0;
        end
        else
        begin
            signalled_system_error <= (signalled_system_error &
                ~(reg_hit(`OFS_PCI_CSR) & wdat[`BIT_SIG_SYS_ERR]))
                | (any_report & system_error_enable);
            received_master_abort <= (received_master_abort &
                ~(reg_hit(`OFS_PCI_CSR) & wdat[`BIT_RCV_MABORT]))
                | ur_like;
            received_target_abort <= (received_target_abort &
                ~(reg_hit(`OFS_PCI_CSR) & wdat[`BIT_RCV_TABORT]))
                | CPL_CA;
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            detected_parity_error  <= 1'b0;
            signalled_target_abort <= 1'b0;
            sec_received_abort     <= 1'b0;
        end
        else
        begin
            detected_parity_error <= (detected_parity_error &
                ~(reg_hit(`OFS_SEC_PCI_STAT) & wdat[`BIT_DET_PERR]))
                | ADDR_PERR | ATTR_PERR;
            signalled_target_abort <= (signalled_target_abort &
                ~(reg_hit(`OFS_SEC_PCI_STAT) & wdat[`BIT_SIG_TABORT]))
                | parity_abort | (ur_like & master_abort_mode);
            sec_received_abort <= (sec_received_abort &
                ~(reg_hit(`OFS_SEC_PCI_STAT) & wdat[`BIT_SEC_RTABORT]))
                | CPL_CA;
        end
    end

    // Detection is flagged for unmasked errors even when no message may go out.
    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            fatal_detected    <= 1'b0;
            nonfatal_detected <= 1'b0;
        end
        else
        begin
            fatal_detected <= (fatal_detected &
                ~(reg_hit(`OFS_DEV_CSR) & wdat[`BIT_FATAL_DET]))
                | (|(sec_hit & sec_sev)) | (to_hit & pri_sev);
            nonfatal_detected <= (nonfatal_detected &
                ~(reg_hit(`OFS_DEV_CSR) & wdat[`BIT_NONFATAL_DET]))
                | (|(sec_hit & ~sec_sev)) | (to_hit & ~pri_sev);
        end
    end

    // Termination seen by the PCI master. PERR on a completion never stops it.
    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            TERM_VALID        <= 1'b0;
            TERM_TARGET_ABORT <= 1'b0;
            TERM_ALL_ONES     <= 1'b0;
            TERM_DISCARD      <= 1'b0;
            STREAM_STOP       <= 1'b0;
        end
        else
        begin
            TERM_VALID        <= ur_like | CPL_CA | parity_abort;
            TERM_TARGET_ABORT <= (ur_like & master_abort_mode) | CPL_CA
                                 | parity_abort;
            TERM_ALL_ONES     <= ur_like & ~master_abort_mode & REQ_IS_READ;
            TERM_DISCARD      <= (ur_like & ~master_abort_mode & ~REQ_IS_READ)
                                 | parity_abort;
            STREAM_STOP       <= CPL_CA;
        end
    end

    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (SRST);

    a_perr_keeps_stream: assert property (RD_PERR && !CPL_CA |=> !STREAM_STOP)
        else $error("Parity error stopped the completion stream.");
    a_perr_status_set: assert property (RD_PERR |=> sec_status[0])
        else $error("Parity assert status not set.");
    a_header_capture: assert property (RD_PERR && !sec_mask[0] && !ptr_valid
        |=> ptr_valid && hdr_log == $past(RD_HDR))
        else $error("Header not captured on first error.");
    a_msg_sent: assert property (RD_PERR && !RD_POISONED && !sec_mask[0]
        && system_error_enable |=> MSG_VALID)
        else $error("Unmasked error sent no message.");
    a_poison_no_msg: assert property (RD_PERR && RD_POISONED && !ADDR_PERR
        && !ATTR_PERR && !CPL_TO && !DT_TIMEOUT |=> !MSG_VALID)
        else $error("Poisoned completion produced a message.");
    a_serr_flag: assert property (MSG_VALID && $past(system_error_enable)
        |-> signalled_system_error)
        else $error("Signalled system error not set.");
    a_fatal_flag: assert property (MSG_VALID && MSG_FATAL |-> fatal_detected)
        else $error("Fatal message without fatal detected.");
    a_parity_abort: assert property (ADDR_PERR && secondary_parity_response_enable
        |=> TERM_TARGET_ABORT && TERM_DISCARD && signalled_target_abort)
        else $error("Address parity not aborted.");
    a_parity_detect: assert property (ADDR_PERR || ATTR_PERR
        |=> detected_parity_error)
        else $error("Detected parity error not set.");
    a_ur_all_ones: assert property (CPL_UR && !master_abort_mode && REQ_IS_READ
        && !CPL_CA |=> TERM_ALL_ONES && !TERM_TARGET_ABORT)
        else $error("Unsupported read did not return ones.");
    a_ur_master_abort: assert property (CPL_UR || CPL_TO
        |=> received_master_abort ##1 (received_master_abort
        || $past(wr_now && AVS_ADDRESS == `OFS_PCI_CSR && AVS_WRITEDATA[`BIT_RCV_MABORT])))
        else $error("Received master abort not held.");
    a_bus_one_wait: assert property ((AVS_READ || AVS_WRITE) && !served
        |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
        else $error("Bus access not served after one wait.");
endmodule // upstream_bridge_error_handler

/* File: tb/upstream_far_end.sv */
// Far-side model: PCI masters and the PCIe link raising error events.
// Assumes the bench calls send only after reset has been released.
module upstream_far_end
(
    input  wire logic        MCLK,
    output logic             RD_PERR,
    output logic             RD_POISONED,
    output logic [31:0]      RD_HDR,
    output logic             ADDR_PERR,
    output logic             ATTR_PERR,
    output logic [31:0]      PCI_HDR,
    output logic             CPL_UR,
    output logic             CPL_CA,
    output logic             CPL_TO,
    output logic             REQ_IS_READ,
    output logic             DT_TIMEOUT
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy = 1'b0;
    initial
    begin
        {DT_TIMEOUT, CPL_TO, CPL_CA, CPL_UR, ATTR_PERR, ADDR_PERR, RD_PERR} = 7'h00;
        {RD_POISONED, REQ_IS_READ, RD_HDR, PCI_HDR} = 66'h0;
    end
    // Idle qualifiers flip every cycle, so a design that samples late never sees a match.
    always @(posedge MCLK)
        if (!busy)
        begin
            RD_HDR <= ~RD_HDR;
            PCI_HDR <= ~PCI_HDR;
            RD_POISONED <= ~RD_POISONED;
            REQ_IS_READ <= ~REQ_IS_READ;
        end
    // Busy rises before the launching edge, so the idle toggler never races the qualifiers.
    // Event codes: 0 parity seen, 1 address, 2 attribute, 3 discard timeout, 4 UR, 5 CA, 6 TO.
    task send(input int k, input logic r, input logic p, input logic [31:0] h);
        busy = 1'b1;
        @(posedge MCLK);
        {CPL_TO, CPL_CA, CPL_UR, DT_TIMEOUT, ATTR_PERR, ADDR_PERR, RD_PERR} <= 7'(7'h01 << k);
        REQ_IS_READ <= r;
        RD_POISONED <= p;
        RD_HDR <= h;
        PCI_HDR <= h;
        @(posedge MCLK);
        {DT_TIMEOUT, CPL_TO, CPL_CA, CPL_UR, ATTR_PERR, ADDR_PERR, RD_PERR} <= 7'h00;
        busy = 1'b0;
    endtask
endmodule // upstream_far_end

/* File: tb/tb_upstream_bridge_error_handler.sv */
// Self-checking bench: a register-image model is compared at every event and readback.
// Assumes one wait state per Avalon access and event answers one cycle after the pulse.
module tb_upstream_bridge_error_handler import upstream_err_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 1'b0;
    logic        srst = 1'b1;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, rd_hdr, pci_hdr;
    logic        avs_waitrequest, rd_perr, rd_poisoned, addr_perr, attr_perr;
    logic        cpl_ur, cpl_ca, cpl_to, req_is_read, dt_timeout, msg_valid, msg_fatal;
    logic        term_valid, term_target_abort, term_all_ones, term_discard, stream_stop;
    logic [31:0] img [12];
    int          seed = 82;
    int          n_fail = 0;
    int          n_tests = 0;
    localparam logic [3:0] rwm [12] = '{4'h0, 4'hF, 4'hF, 4'h0, 4'h0, 4'h0, 4'h1, 4'h1,
                                        4'h1, 4'h0, 4'h7, 4'h3};
    localparam logic [3:0] w1c [12] = '{4'hF, 4'h0, 4'h0, 4'h0, 4'h0, 4'h1, 4'h0, 4'h0,
                                        4'hE, 4'h7, 4'h0, 4'hC};
    always #5 mclk = ~mclk;
    upstream_bridge_error_handler i_upstream_bridge_error_handler (.MCLK(mclk), .SRST(srst),
        .AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write),
        .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(avs_readdata),
        .AVS_WAITREQUEST(avs_waitrequest), .RD_PERR(rd_perr), .RD_POISONED(rd_poisoned),
        .RD_HDR(rd_hdr), .ADDR_PERR(addr_perr), .ATTR_PERR(attr_perr), .PCI_HDR(pci_hdr),
        .CPL_UR(cpl_ur), .CPL_CA(cpl_ca), .CPL_TO(cpl_to), .REQ_IS_READ(req_is_read),
        .DT_TIMEOUT(dt_timeout), .MSG_VALID(msg_valid), .MSG_FATAL(msg_fatal),
        .TERM_VALID(term_valid), .TERM_TARGET_ABORT(term_target_abort),
        .TERM_ALL_ONES(term_all_ones), .TERM_DISCARD(term_discard), .STREAM_STOP(stream_stop));
    upstream_far_end i_upstream_far_end (.MCLK(mclk), .RD_PERR(rd_perr),
        .RD_POISONED(rd_poisoned), .RD_HDR(rd_hdr), .ADDR_PERR(addr_perr),
        .ATTR_PERR(attr_perr), .PCI_HDR(pci_hdr), .CPL_UR(cpl_ur), .CPL_CA(cpl_ca),
        .CPL_TO(cpl_to), .REQ_IS_READ(req_is_read), .DT_TIMEOUT(dt_timeout));
    task report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int k;
        @(posedge mclk);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        for (k = 0; k < 20; k++)
        begin
            @(posedge mclk);
            if (avs_waitrequest === 1'b0)
                break;
        end
        if (k == 20)
        begin
            n_fail++;
            report_and_stop();
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task cfg(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        int          i;
        i = a >> 2;
        bus(1'b1, a, d, q);
        img[i] = (img[i] & ~32'(rwm[i]) & ~(d & 32'(w1c[i]))) | (d & 32'(rwm[i]));
        if (i == 3 && d[7]) img[3] = 32'h0;
    endtask
    task check_regs(input string nm);
        logic [31:0] q;
        for (int i = 0; i < 12; i++)
        begin
            bus(1'b0, 8'(i * 4), 32'h0, q);
            if (i == 3) q = q & (q[7] ? 32'h83 : 32'h80);
            chk($sformatf("register %0h", i * 4), img[i], q);
        end
        bus(1'b0, 8'h40, 32'h0, q);
        chk("unmapped", 32'h0, q);
        $display("test %s done", nm);
    endtask
    task ev(input int k, input logic r, input logic p);
        logic [31:0] h;
        logic        rep, sv, msg, pa, ur, ab;
        logic [6:0]  e, g;
        h = $random(seed);
        pa = (k == 1 || k == 2);
        ur = (k == 4 || k == 6);
        rep = (k < 3) ? !img[1][k] : (k == 3) ? (!img[1][3] | img[10][2]) :
              (k == 6) ? !img[6][0] : 1'b0;
        sv = (k == 6) ? img[7][0] : img[2][k % 4];
        msg = rep & !p & (img[8][0] | (sv ? img[11][0] : img[11][1]));
        ab = (pa & img[10][0]) | (ur & img[10][1]) | (k == 5);
        e = {msg, msg & sv, (k > 3) | (pa & img[10][0]), ab, ur & !img[10][1] & r, k == 5,
             (ur & !img[10][1] & !r) | (pa & img[10][0])};
        if (rep) img[11][sv ? 2 : 3] = 1'b1;
        if (msg & img[8][0]) img[8][1] = 1'b1;
        if (k < 4) img[0][k] = 1'b1;
        if (k == 6) img[5][0] = 1'b1;
        if (k < 3 && !img[1][k] && !img[3][7])
        begin
            img[3] = 32'h80 | 32'(k);
            img[4] = h;
        end
        if (ur) img[8][2] = 1'b1;
        if (k == 5) img[8][3] = 1'b1;
        if (k == 5) img[9][2] = 1'b1;
        if (pa) img[9][0] = 1'b1;
        if (ab && k != 5) img[9][1] = 1'b1;
        i_upstream_far_end.send(k, r, p, h);
        #1;
        g = {msg_valid, msg_valid & msg_fatal, term_valid, term_valid & term_target_abort,
             term_valid & term_all_ones, stream_stop, term_valid & term_discard};
        chk($sformatf("event %0d outputs", k), 32'(e), 32'(g));
        @(posedge mclk);
        #1;
        chk("message pulse", 32'h0, 32'(msg_valid));
    endtask
    initial
    begin
        for (int i = 0; i < 12; i++) img[i] = 32'h0;
        repeat (12) @(posedge mclk);
        srst <= 1'b0;
        check_regs("reset");
        ev(4, 1'b1, 1'b0);
        ev(4, 1'b0, 1'b0);
        ev(6, 1'b1, 1'b0);
        check_regs("unsupported");
        cfg(8'h2C, 32'h3);
        cfg(8'h08, 32'h1);
        cfg(8'h20, 32'h1);
        ev(0, 1'b1, 1'b0);
        ev(0, 1'b1, 1'b1);
        ev(6, 1'b0, 1'b0);
        check_regs("parity seen");
        cfg(8'h28, 32'h3);
        cfg(8'h0C, 32'h80);
        ev(1, 1'b1, 1'b0);
        ev(2, 1'b0, 1'b0);
        ev(4, 1'b0, 1'b0);
        ev(5, 1'b1, 1'b0);
        check_regs("aborts");
        cfg(8'h04, 32'hF);
        cfg(8'h28, 32'h4);
        cfg(8'h20, 32'h0);
        ev(3, 1'b1, 1'b0);
        ev(1, 1'b0, 1'b0);
        cfg(8'h28, 32'h0);
        ev(3, 1'b0, 1'b0);
        check_regs("timeouts");
        // Parity response stays on here, since with it off the notes leave reporting open.
        for (int i = 0; i < 8; i++)
        begin
            cfg(8'h04, $random(seed));
            cfg(8'h08, $random(seed));
            cfg(8'h28, $random(seed) | 1);
            ev({$random(seed)} % 7, 1'($random(seed)), 1'b0);
        end
        check_regs("random");
        cfg(8'h00, 32'hF);
        cfg(8'h14, 32'h1);
        cfg(8'h20, 32'hE);
        cfg(8'h24, 32'h7);
        cfg(8'h2C, 32'hC);
        cfg(8'h0C, 32'h80);
        check_regs("clear");
        report_and_stop();
    end
endmodule // tb_upstream_bridge_error_handler
